/* bench/jesd_tx_model.sv */
// behavioural model of the far-end transmitter as seen through link status
`timescale 1ns/1ps
module jesd_tx_model #(
    parameter int LAT = 2
)
(
    input wire logic clk,
    input wire logic up_req,
    input wire logic crc_req,
    output logic released,
    output logic crc_fault,
    output logic sync_n
);
    int cnt = 0;
    // lanes need a few cycles to align, so release never follows the request at once
    always @(posedge clk)
    begin
        cnt <= up_req ? cnt + 1 : 0;
    end
    assign released = up_req && (cnt >= LAT);
    assign crc_fault = crc_req;
    // sync request stays asserted until the buffer is released
    assign sync_n = released;
endmodule : jesd_tx_model

/* bench/tb_serdes_pll_test_watchdog_ctrl.sv */
// self-checking bench for the pll, test and watchdog register bank
`timescale 1ns/1ps
module tb_serdes_pll_test_watchdog_ctrl;
    import serdes_cfg_pkg::*;
    // thresholds shortened so the run stays short; code 1 then expires after THR counts
    localparam int THR_RED = 8;
    localparam int THR = 1 << (WD_THR_EXP_1 - THR_RED);
    logic clk = 0, rst = 1, wr = 0, rd = 0, en = 0, enc = 0, up = 0, crc = 0;
    logic [11:0] addr = '0;
    logic [7:0] wdata = '0, rdata, mult;
    logic [1:0] rate;
    logic [2:0] prbs;
    logic vco, prbs_en, bad, sync_n, rx_rst, pll_rst, rel, crcf, lsync, seen;
    logic [7:0] mults[4] = '{MULT_X4, MULT_X5, MULT_X8P25, MULT_X10};
    int miscompares = 0, compares = 0, n;
    always #20 clk = ~clk;

    serdes_pll_test_watchdog_ctrl #(.ADDR_W(12), .WD_THR_REDUCE(THR_RED))
        serdes_pll_test_watchdog_ctrl_i (.I_CLK_SYS(clk), .I_RST(rst),
        .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .I_LINK_ENABLE(en), .I_ENCODING_SELECT(enc), .I_ELASTIC_RELEASED(rel),
        .I_CRC_FAULT(crcf), .I_LINK_SYNC_N(lsync), .O_PLL_MULTIPLIER_CODE(mult),
        .O_LANE_RATE_CODE(rate), .O_VCO_LOW_BAND(vco), .O_PRBS_PATTERN_CODE(prbs),
        .O_PRBS_ENABLE(prbs_en), .O_CFG_INVALID(bad), .O_SYNC_N(sync_n), .O_RX_RESET(rx_rst),
        .O_PLL_RESET(pll_rst));
    jesd_tx_model jesd_tx_model_i (.clk(clk), .up_req(up), .crc_req(crc), .released(rel),
        .crc_fault(crcf), .sync_n(lsync));

    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // inputs move 1 ns after the edge so the design never races the bench
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    // an idle cycle follows each write so the strobe is never re-driven in one step
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1;
        tick(1);
        wr = 0;
        tick(1);
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp, input string what);
        addr = a;
        rd = 1;
        tick(1);
        rd = 0;
        chk(what, exp, rdata);
        tick(1);
    endtask : reg_rd

    // waits for the receiver reset; exp_n counts edges from the call to the first reset cycle
    task automatic wait_expiry(input int exp_n, input logic exp_pll);
        int k;
        for (k = 0; k < 4 * THR && rx_rst !== 1'b1; k++)
            tick(1);
        if (rx_rst !== 1'b1)
        begin
            miscompares++;
            $display("[FAIL] rx_reset expected 1 seen %b", rx_rst);
            give_verdict();
        end
        else
        begin
            chk("expiry_cycles", 8'h01, 8'(k == exp_n));
            chk("pll_reset", 8'(exp_pll), 8'(pll_rst));
            tick(PHY_RST_CYCLES - 1);
            chk("rx_reset_len", 8'h01, 8'(rx_rst));
            tick(1);
            chk("rx_reset_end", 8'h00, 8'(rx_rst));
        end
    endtask : wait_expiry

    initial
    begin
        tick(20);
        rst = 0;
        tick(1);
        reg_rd(ADDR_PLL_MULT, RST_PLL_MULT, "pll_mult");
        reg_rd(ADDR_LANE_RATE, RST_LANE_RATE, "lane_rate");
        reg_rd(ADDR_VCO_BAND, RST_VCO_BAND, "vco_band");
        reg_rd(ADDR_MAN_SYNC, RST_MAN_SYNC, "man_sync");
        reg_rd(ADDR_PRBS, RST_PRBS, "prbs");
        reg_rd(ADDR_WDOG, RST_WDOG, "wdog");
        reg_rd(12'h10c, 8'h00, "unmapped");
        chk("mult_out", RST_PLL_MULT, mult);
        foreach (mults[k])
        begin
            reg_wr(ADDR_PLL_MULT, mults[k]);
            chk("mult_out", mults[k], mult);
            chk("cfg_invalid", 8'h00, 8'(bad));
        end
        reg_wr(ADDR_PLL_MULT, 8'h11);
        chk("cfg_invalid", 8'h01, 8'(bad));
        reg_rd(ADDR_PLL_MULT, 8'h11, "pll_mult");
        reg_wr(ADDR_PLL_MULT, MULT_X4);
        reg_wr(ADDR_VCO_BAND, 8'h01);
        chk("vco", 8'h01, 8'(vco));
        for (int k = 0; k < 4; k++)
        begin
            reg_wr(ADDR_LANE_RATE, 8'(k));
            chk("rate_out", 8'(k), 8'(rate));
        end
        for (int k = 0; k < 7; k++)
        begin
            reg_wr(ADDR_PRBS, 8'(k));
            chk("prbs_code", (k <= PRBS_MAX_CODE) ? 8'(k) : 8'h00, 8'(prbs));
            chk("prbs_en", 8'(k >= 1 && k <= PRBS_MAX_CODE), 8'(prbs_en));
        end
        up = 1;
        tick(8);
        reg_rd(ADDR_STATUS, 8'h60, "status_up");
        chk("sync_n", 8'h01, 8'(sync_n));
        reg_wr(ADDR_MAN_SYNC, 8'h00);
        chk("sync_n", 8'h00, 8'(sync_n));
        reg_wr(ADDR_MAN_SYNC, 8'h01);
        chk("sync_n", 8'h01, 8'(sync_n));
        up = 0;
        tick(6);
        reg_rd(ADDR_STATUS, 8'h00, "status_down");
        en = 1;
        tick(1);
        reg_wr(ADDR_LANE_RATE, 8'h01);
        chk("rate_frozen", 8'h03, 8'(rate));
        en = 0;
        tick(1);
        chk("rate_applied", 8'h01, 8'(rate));
        reg_wr(ADDR_WDOG, 8'h81);
        reg_rd(ADDR_WDOG, 8'h81, "wdog");
        en = 1;
        // link held down, so the counter climbs every cycle to the smallest threshold
        wait_expiry(THR, 1'b1);
        en = 0;
        tick(2);
        // step 16 and no pll reset; the link comes up at half threshold and must hold it off
        reg_wr(ADDR_WDOG, 8'h31);
        en = 1;
        tick(THR / 2);
        up = 1;
        seen = 0;
        for (n = 0; n < 3 * THR; n++)
        begin
            tick(1);
            if (rx_rst !== 1'b0)
                seen = 1;
        end
        chk("reset_while_up", 8'h00, 8'(seen));
        // a crc fault makes an up link count again, two synchroniser stages late
        crc = 1;
        wait_expiry(THR + 2, 1'b0);
        crc = 0;
        up = 0;
        en = 0;
        tick(2);
        give_verdict();
    end
endmodule : tb_serdes_pll_test_watchdog_ctrl

/* rtl/serdes_cfg_pkg.sv */
// constants for the serial receiver pll, test and watchdog register bank
package serdes_cfg_pkg;
    localparam logic [11:0] ADDR_PLL_MULT = 12'h109;
    localparam logic [11:0] ADDR_LANE_RATE = 12'h10a;
    localparam logic [11:0] ADDR_VCO_BAND = 12'h10b;
    localparam logic [11:0] ADDR_MAN_SYNC = 12'h120;
    localparam logic [11:0] ADDR_PRBS = 12'h121;
    localparam logic [11:0] ADDR_WDOG = 12'h124;
    localparam logic [11:0] ADDR_STATUS = 12'h107;
    localparam logic [7:0] RST_PLL_MULT = 8'h14;
    localparam logic [7:0] RST_LANE_RATE = 8'h00;
    localparam logic [7:0] RST_VCO_BAND = 8'h00;
    localparam logic [7:0] RST_MAN_SYNC = 8'h01;
    localparam logic [7:0] RST_PRBS = 8'h00;
    localparam logic [7:0] RST_WDOG = 8'h00;
    localparam logic [7:0] MULT_X4 = 8'h10;
    localparam logic [7:0] MULT_X5 = 8'h14;
    localparam logic [7:0] MULT_X8P25 = 8'h21;
    localparam logic [7:0] MULT_X10 = 8'h28;
    localparam int PRBS_MAX_CODE = 4;
    localparam int WD_PLL_BIT = 7;
    localparam int WD_DEC_LSB = 4;
    localparam int WD_THR_LSB = 0;
    localparam int STAT_LINK_UP_BIT = 6;
    localparam int STAT_SYNC_BIT = 5;
    localparam int WD_THR_EXP_1 = 17;
    localparam int WD_THR_EXP_2 = 19;
    localparam int WD_THR_EXP_3 = 32;
    localparam int WD_THR_EXP_4 = 23;
    localparam int WD_STEP_0 = 1;
    localparam int WD_STEP_1 = 2;
    localparam int WD_STEP_2 = 8;
    localparam int WD_STEP_3 = 16;
    localparam int WD_CNT_W = 33;
    localparam int PHY_RST_CYCLES = 4;
endpackage : serdes_cfg_pkg

/* rtl/serdes_pll_test_watchdog_ctrl.sv */
// serial receiver pll, prbs test and link watchdog register bank
//
// What this block does
// - The pll multiplier register takes codes 10h,14h,21h,28h for x4,x5,x8.25,x10, reset 14h.
// - A two-bit lane rate field selects pll-to-lane multiplier 4,2,1,0.5 for codes 0..3.
// - Writing 0 to the manual sync bit forces the active-low sync output while I_ENCODING_SELECT is low; it resets to 1.
// - A five-bit test code selects normal (0) or prbs7/9/15/31 (1..4); 5..31 reserved.
// - Watchdog expiry resets the receiver, and the pll too when bit 7 is set.
// - While the link is up without crc fault the counter drops by 1, 2, 8 or 16.
// - Reaching the threshold resets phy and watchdog; code 0 disables, 1..4 pick 2^17, 2^19, 2^32, 2^23.
// - Link up means elastic buffer released, shown in a read-only status flag.
`timescale 1ns/1ps
module serdes_pll_test_watchdog_ctrl
    import serdes_cfg_pkg::*;
#(
    parameter int ADDR_W = 12,
    // lowers every threshold exponent by this much; 0 keeps the full thresholds
    parameter int WD_THR_REDUCE = 0
)
(
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // serial control port, already in this clock domain
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [ADDR_W-1:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    // link controls and status from the receiver
    input wire logic I_LINK_ENABLE,
    input wire logic I_ENCODING_SELECT,
    input wire logic I_ELASTIC_RELEASED,
    input wire logic I_CRC_FAULT,
    input wire logic I_LINK_SYNC_N,
    // applied configuration
    output logic [7:0] O_PLL_MULTIPLIER_CODE,
    output logic [1:0] O_LANE_RATE_CODE,
    output logic O_VCO_LOW_BAND,
    output logic [2:0] O_PRBS_PATTERN_CODE,
    output logic O_PRBS_ENABLE,
    output logic O_CFG_INVALID,
    // sync and resets toward the phy
    output logic O_SYNC_N,
    output logic O_RX_RESET,
    output logic O_PLL_RESET
);
    import serdes_cfg_pkg::*;

    // offsets need 12 address bits, and the smallest threshold must stay above one count
    if (ADDR_W < 12)
    begin : g_addr_w_check
        $error("ADDR_W too small for register offsets");
    end
    if (WD_THR_REDUCE < 0 || WD_THR_REDUCE >= WD_THR_EXP_1)
    begin : g_thr_reduce_check
        $error("WD_THR_REDUCE out of range");
    end

    typedef struct packed {
        logic [7:0] pll_mult;
        logic [1:0] lane_rate;
        logic vco_low_band;
        logic manual_sync_bit;
        logic [4:0] prbs_code;
        logic [7:0] watchdog_config;
        logic [7:0] ap_mult;
        logic [1:0] ap_rate;
        logic ap_vco;
        logic [4:0] ap_prbs;
        logic en_q;
        logic [WD_CNT_W-1:0] wd_cnt;
        logic [2:0] rst_cnt;
        logic rst_pll;
        logic link_up;
        logic [7:0] rdata;
        logic [1:0] link_up_sync;
        logic [1:0] crc_sync;
        logic [1:0] sync_n_sync;
    } state_t;

    state_t st;
    state_t next_st;

    // threshold code to count; 2^32 kept as printed
    function automatic logic [WD_CNT_W-1:0] wd_threshold(input logic [2:0] code);
        unique case (code)
            3'h1: wd_threshold = WD_CNT_W'(1) << (WD_THR_EXP_1 - WD_THR_REDUCE);
            3'h2: wd_threshold = WD_CNT_W'(1) << (WD_THR_EXP_2 - WD_THR_REDUCE);
            3'h3: wd_threshold = WD_CNT_W'(1) << (WD_THR_EXP_3 - WD_THR_REDUCE);
            3'h4: wd_threshold = WD_CNT_W'(1) << (WD_THR_EXP_4 - WD_THR_REDUCE);
            default: wd_threshold = '0;
        endcase
    endfunction : wd_threshold

    function automatic logic [WD_CNT_W-1:0] wd_decrement(input logic [1:0] code);
        unique case (code)
            2'h0: wd_decrement = WD_CNT_W'(WD_STEP_0);
            2'h1: wd_decrement = WD_CNT_W'(WD_STEP_1);
            2'h2: wd_decrement = WD_CNT_W'(WD_STEP_2);
            default: wd_decrement = WD_CNT_W'(WD_STEP_3);
        endcase
    endfunction : wd_decrement

    function automatic logic mult_legal(input logic [7:0] code);
        mult_legal = (code == MULT_X4) || (code == MULT_X5) ||
                     (code == MULT_X8P25) || (code == MULT_X10);
    endfunction : mult_legal

    // buffer release, crc fault and link sync inputs pass two flip-flops kept in the state struct; only stage 1 is read
    logic [1:0] sync_link_up;
    logic [1:0] sync_crc;
    logic [1:0] sync_sync_n;
    assign sync_link_up = st.link_up_sync;
    assign sync_crc = st.crc_sync;
    assign sync_sync_n = st.sync_n_sync;

    logic [2:0] thr_code;
    logic [1:0] dec_code;
    logic [WD_CNT_W-1:0] thr;
    logic [WD_CNT_W-1:0] dec;
    assign thr_code = st.watchdog_config[WD_THR_LSB +: 3];
    assign dec_code = st.watchdog_config[WD_DEC_LSB +: 2];
    assign thr = wd_threshold(thr_code);
    assign dec = wd_decrement(dec_code);

    always_comb
    begin
        next_st = st;
        next_st.en_q = I_LINK_ENABLE;
        next_st.link_up_sync = {st.link_up_sync[0], I_ELASTIC_RELEASED};
        next_st.crc_sync = {st.crc_sync[0], I_CRC_FAULT};
        next_st.sync_n_sync = {st.sync_n_sync[0], I_LINK_SYNC_N};
        next_st.link_up = sync_link_up[1];
        if (I_REG_WR)
        begin
            unique case (I_REG_ADDR[11:0])
                ADDR_PLL_MULT: next_st.pll_mult = I_REG_WDATA;
                ADDR_LANE_RATE: next_st.lane_rate = I_REG_WDATA[1:0];
                ADDR_VCO_BAND: next_st.vco_low_band = I_REG_WDATA[0];
                ADDR_MAN_SYNC: next_st.manual_sync_bit = I_REG_WDATA[0];
                ADDR_PRBS: next_st.prbs_code = I_REG_WDATA[4:0];
                ADDR_WDOG: next_st.watchdog_config = I_REG_WDATA;
                default: ;
            endcase
        end
        // apply settings while disabled and at the rising link enable
        if (!I_LINK_ENABLE || !st.en_q)
        begin
            next_st.ap_mult = next_st.pll_mult;
            next_st.ap_rate = next_st.lane_rate;
            next_st.ap_vco = next_st.vco_low_band;
            next_st.ap_prbs = next_st.prbs_code;
        end
        next_st.rdata = 8'h00;
        if (I_REG_RD)
        begin
            unique case (I_REG_ADDR[11:0])
                ADDR_PLL_MULT: next_st.rdata = st.pll_mult;
                ADDR_LANE_RATE: next_st.rdata = {6'h00, st.lane_rate};
                ADDR_VCO_BAND: next_st.rdata = {7'h00, st.vco_low_band};
                ADDR_MAN_SYNC: next_st.rdata = {7'h00, st.manual_sync_bit};
                ADDR_PRBS: next_st.rdata = {3'h0, st.prbs_code};
                ADDR_WDOG: next_st.rdata = st.watchdog_config;
                ADDR_STATUS:
                begin
                    next_st.rdata[STAT_LINK_UP_BIT] = st.link_up;
                    next_st.rdata[STAT_SYNC_BIT] = O_SYNC_N;
                end
                default: next_st.rdata = 8'h00;
            endcase
        end
        // watchdog; only runs with the link enabled and a legal threshold
        if (st.rst_cnt != '0)
            next_st.rst_cnt = st.rst_cnt - 3'h1;
        if (!I_LINK_ENABLE || thr == '0)
            next_st.wd_cnt = '0;
        else if (st.link_up && !sync_crc[1])
            next_st.wd_cnt = (st.wd_cnt > dec) ? st.wd_cnt - dec : '0;
        else if (st.wd_cnt + WD_CNT_W'(1) >= thr)
        begin
            next_st.wd_cnt = '0;
            next_st.rst_cnt = 3'(PHY_RST_CYCLES);
            next_st.rst_pll = st.watchdog_config[WD_PLL_BIT];
        end
        else
            next_st.wd_cnt = st.wd_cnt + WD_CNT_W'(1);
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            st <= '0;
            st.pll_mult <= RST_PLL_MULT;
            st.ap_mult <= RST_PLL_MULT;
            st.lane_rate <= RST_LANE_RATE[1:0];
            st.vco_low_band <= RST_VCO_BAND[0];
            st.manual_sync_bit <= RST_MAN_SYNC[0];
            st.prbs_code <= RST_PRBS[4:0];
            st.watchdog_config <= RST_WDOG;
            // sync chain idles deasserted so no false request follows reset
            st.sync_n_sync <= '1;
        end
        else
            st <= next_st;
    end

    assign O_REG_RDATA = st.rdata;
    assign O_PLL_MULTIPLIER_CODE = st.ap_mult;
    assign O_LANE_RATE_CODE = st.ap_rate;
    assign O_VCO_LOW_BAND = st.ap_vco;
    // reserved prbs codes fall back to normal reception
    assign O_PRBS_ENABLE = (st.ap_prbs != 5'h00) && (st.ap_prbs <= 5'(PRBS_MAX_CODE));
    assign O_PRBS_PATTERN_CODE = O_PRBS_ENABLE ? st.ap_prbs[2:0] : 3'h0;
    assign O_CFG_INVALID = !mult_legal(st.ap_mult);
    // a 64b/66b link ignores the manual bit: combination is undefined anyway
    assign O_SYNC_N = sync_sync_n[1] & (st.manual_sync_bit | I_ENCODING_SELECT);
    assign O_RX_RESET = (st.rst_cnt != '0);
    assign O_PLL_RESET = O_RX_RESET && st.rst_pll;

    manual_sync_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (!st.manual_sync_bit && !I_ENCODING_SELECT) |-> !O_SYNC_N)
        else $error("sync not forced by manual bit");
    pll_rst_gate_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        O_PLL_RESET |-> O_RX_RESET)
        else $error("pll reset without receiver reset");
    sequence expire_s;
        (st.rst_cnt == '0) ##1 (st.rst_cnt == 3'(PHY_RST_CYCLES));
    endsequence
    rx_rst_len_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        expire_s |-> O_RX_RESET [*4] ##1 !O_RX_RESET)
        else $error("receiver reset pulse length wrong");
    wd_dec_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_LINK_ENABLE && thr != '0 && st.link_up && !sync_crc[1] && st.wd_cnt > dec
         && $stable(st.watchdog_config))
        |=> st.wd_cnt == $past(st.wd_cnt) - $past(dec))
        else $error("watchdog decrement wrong");
    wd_floor_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_LINK_ENABLE && thr != '0 && st.link_up && !sync_crc[1] && st.wd_cnt <= dec)
        |=> st.wd_cnt == '0)
        else $error("watchdog counter not floored at zero");
    wd_off_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (thr_code == 3'h0 && st.rst_cnt == '0) |=> (st.wd_cnt == '0 && st.rst_cnt == '0))
        else $error("disabled watchdog counted");
    wd_bound_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (thr != '0 && $stable(thr)) |-> st.wd_cnt < thr)
        else $error("watchdog counter passed threshold");
    prbs_code_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (st.ap_prbs > 5'(PRBS_MAX_CODE)) |-> !O_PRBS_ENABLE)
        else $error("reserved prbs code enabled test");
    cfg_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        (I_LINK_ENABLE && st.en_q) |=> $stable(O_PLL_MULTIPLIER_CODE))
        else $error("multiplier changed while link enabled");
    link_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
        sync_link_up[1] |=> st.link_up)
        else $error("link up flag not following buffer release");
endmodule : serdes_pll_test_watchdog_ctrl
